// ==== core/fplc_ctrl.sv ====
// Fuse program and load controller with setting record parser
//
// Contract
// R01: Mode bit 6 set selects partial range, clear selects all bytes.
// R02: Start and end addresses come from high and low byte register pairs.
// R03: Program trigger bit 0 burns buffer bytes of the range into fuses.
// R04: Program busy bit 7 is high during programming, low when done.
// R05: Host polls program busy until it reads zero.
// R06: Host fills buffer bytes of the range before programming.
// R07: Load trigger bit 0 copies fuses to buffer, only the range if partial.
// R08: Load busy bit 7 is high during a load, low when it finishes.
// R09: All-byte load copies all 1024 bytes into buffer 0x7000 to 0x73FF.
// R10: First setting record address comes from the header register pair.
// R11: With auto-load, fill buffer first, then parse records into registers.
// R12: Fuses load at start-up; autoload bit 2 clear means no streaming reload.
// R13: With bit 2 set, bit 3 picks first streaming entry or every entry.
// R14: Autoload bit 1 enables parsing for automatic loads, bit 0 for manual.
// R15: Command A with n takes a two-byte address then n+1 data bytes.
// R16: Command 5 with n continues after the last written address.
// R17: Record data bytes go to consecutive incrementing register addresses.
// R18: Records are contiguous and the first uses the explicit address form.
// R19: The record range holds at least one spare byte.
// R20: Host starts no load while partial programming is set up or running.
// R21: Fuse offset k maps to buffer address 0x7000 plus k.
// R22: Host keeps the device streaming while it triggers programming.
// R23: Parser stops on an unknown command nibble or at the range end.
// R24: Busy bits are read-only; triggers while busy are ignored.
`include "fplc_defs.svh"

module fplc_ctrl
    import fplc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port of the serial control bus
    input wire fplc_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    // Device streaming state
    input wire logic stream_on_i,
    // Fuse array macro
    output fplc_fuse_cmd_s fuse_cmd_o,
    input wire logic fuse_ack_i,
    input wire logic [7:0] fuse_rdata_i,
    // Decoded setting writes into device registers
    output fplc_dev_wr_s dev_wr_o
);
    fplc_ctrl_s cur;
    fplc_ctrl_s next_cur;
    logic buf_we;
    logic [9:0] buf_wi;
    logic [7:0] buf_wd;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [9:0] lo;
    logic [9:0] hi;
    logic prog_busy;
    logic load_busy;
    logic in_buf;
    logic stream_rise;
    logic fuse_done;

    fplc_stage_buf u_buf (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(buf_we),
        .wr_idx_i(buf_wi),
        .wr_data_i(buf_wd),
        .rd_a_idx_i(reg_req_i.addr[9:0]),
        .rd_a_data_o(buf_a),
        .rd_b_idx_i(cur.idx),
        .rd_b_data_o(buf_b)
    );

    always_comb begin
        next_cur = cur;
        next_cur.dev.we = 1'b0;
        buf_we = 1'b0;
        buf_wi = cur.idx;
        buf_wd = fuse_rdata_i;
        // R01 mode select
        // R02 range pairs
        // R09 all bytes
        if (cur.mode[`FPLC_BIT_PARTIAL]) begin
            lo = cur.start_addr[9:0];
            hi = cur.end_addr[9:0];
        end else begin
            lo = `FPLC_IDX_FIRST;
            hi = `FPLC_IDX_LAST;
        end
        // R04 R08 busy flags
        prog_busy = (cur.st == FPLC_PROG);
        load_busy = !prog_busy && (cur.st != FPLC_IDLE);
        in_buf = (reg_req_i.addr >= `FPLC_BUF_FIRST) && (reg_req_i.addr <= `FPLC_BUF_LAST);
        stream_rise = stream_on_i && !cur.stream_q;
        fuse_done = cur.fuse.req && fuse_ack_i;
        next_cur.stream_q = stream_on_i;

        // R24 busy read-only
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `FPLC_OFF_PROG: next_cur.rdata = {prog_busy, 7'h00};
                `FPLC_OFF_LOAD: next_cur.rdata = {load_busy, 7'h00};
                `FPLC_OFF_MODE: next_cur.rdata = cur.mode;
                `FPLC_OFF_AUTOLOAD: next_cur.rdata = cur.autoload;
                `FPLC_OFF_START_HI: next_cur.rdata = cur.start_addr[15:8];
                `FPLC_OFF_START_LO: next_cur.rdata = cur.start_addr[7:0];
                `FPLC_OFF_END_HI: next_cur.rdata = cur.end_addr[15:8];
                `FPLC_OFF_END_LO: next_cur.rdata = cur.end_addr[7:0];
                `FPLC_OFF_HDR_HI: next_cur.rdata = cur.hdr_addr[15:8];
                `FPLC_OFF_HDR_LO: next_cur.rdata = cur.hdr_addr[7:0];
                default: next_cur.rdata = in_buf ? buf_a : `FPLC_RST_BYTE;
            endcase
        end

        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `FPLC_OFF_MODE: next_cur.mode = reg_req_i.wdata;
                `FPLC_OFF_AUTOLOAD: next_cur.autoload = reg_req_i.wdata;
                `FPLC_OFF_START_HI: next_cur.start_addr[15:8] = reg_req_i.wdata;
                `FPLC_OFF_START_LO: next_cur.start_addr[7:0] = reg_req_i.wdata;
                `FPLC_OFF_END_HI: next_cur.end_addr[15:8] = reg_req_i.wdata;
                `FPLC_OFF_END_LO: next_cur.end_addr[7:0] = reg_req_i.wdata;
                // R10 header pair
                `FPLC_OFF_HDR_HI: next_cur.hdr_addr[15:8] = reg_req_i.wdata;
                `FPLC_OFF_HDR_LO: next_cur.hdr_addr[7:0] = reg_req_i.wdata;
                default: begin
                    // Host buffer writes only while idle, so a running transfer owns the port
                    if (in_buf && cur.st == FPLC_IDLE) begin
                        buf_we = 1'b1;
                        buf_wi = reg_req_i.addr[9:0];
                        buf_wd = reg_req_i.wdata;
                    end
                end
            endcase
        end

        // R13 streaming reload
        if (stream_rise) begin
            next_cur.first_done = 1'b1;
        end

        case (cur.st)
            FPLC_IDLE: begin
                // R03 program trigger
                // R24 ignore when busy
                if (reg_req_i.wr && reg_req_i.addr == `FPLC_OFF_PROG && reg_req_i.wdata[`FPLC_BIT_TRIG]) begin
                    next_cur.st = FPLC_PROG;
                    next_cur.idx = lo;
                    next_cur.last = hi;
                // R07 load trigger
                end else if (reg_req_i.wr && reg_req_i.addr == `FPLC_OFF_LOAD
                             && reg_req_i.wdata[`FPLC_BIT_TRIG]) begin
                    next_cur.st = FPLC_LOAD;
                    next_cur.idx = lo;
                    next_cur.last = hi;
                    next_cur.auto_run = 1'b0;
                // R12 start-up load
                end else if (cur.boot_pend || cur.stream_pend) begin
                    next_cur.st = FPLC_LOAD;
                    next_cur.idx = lo;
                    next_cur.last = hi;
                    next_cur.auto_run = 1'b1;
                    next_cur.boot_pend = 1'b0;
                    next_cur.stream_pend = 1'b0;
                end
            end
            FPLC_PROG, FPLC_LOAD: begin
                if (!cur.fuse.req) begin
                    // R21 direct mapping
                    next_cur.fuse.req = 1'b1;
                    next_cur.fuse.we = prog_busy;
                    next_cur.fuse.addr = cur.idx;
                    next_cur.fuse.wdata = buf_b;
                end else if (fuse_done) begin
                    next_cur.fuse.req = 1'b0;
                    next_cur.fuse.we = 1'b0;
                    next_cur.idx = cur.idx + 10'h001;
                    // R07 copy into buffer
                    buf_we = load_busy;
                    buf_wi = cur.fuse.addr;
                    buf_wd = fuse_rdata_i;
                    if (cur.idx == cur.last) begin
                        next_cur.st = FPLC_IDLE;
                        next_cur.idx = cur.hdr_addr[9:0];
                        // R11 second stage
                        // R14 parse enables
                        if (load_busy && (cur.auto_run ? cur.autoload[`FPLC_BIT_AL_AUTO]
                                                       : cur.autoload[`FPLC_BIT_AL_MANUAL])) begin
                            next_cur.st = FPLC_CMD;
                        end
                    end
                end
            end
            FPLC_CMD: begin
                next_cur.idx = cur.idx + 10'h001;
                next_cur.cnt = buf_b[3:0];
                // R15 absolute record
                // R16 following record
                // R23 stop on bad code
                if (buf_b[7:4] == `FPLC_CMD_ABSOLUTE) begin
                    next_cur.st = FPLC_ADRH;
                end else if (buf_b[7:4] == `FPLC_CMD_FOLLOWING) begin
                    next_cur.st = FPLC_DATA;
                end else begin
                    next_cur.st = FPLC_IDLE;
                end
            end
            FPLC_ADRH: begin
                next_cur.idx = cur.idx + 10'h001;
                next_cur.dev_addr[15:8] = buf_b;
                next_cur.st = FPLC_ADRL;
            end
            FPLC_ADRL: begin
                next_cur.idx = cur.idx + 10'h001;
                next_cur.dev_addr[7:0] = buf_b;
                next_cur.st = FPLC_DATA;
            end
            FPLC_DATA: begin
                next_cur.idx = cur.idx + 10'h001;
                // R17 incrementing writes
                next_cur.dev.we = 1'b1;
                next_cur.dev.addr = cur.dev_addr;
                next_cur.dev.data = buf_b;
                next_cur.dev_addr = cur.dev_addr + 16'h0001;
                next_cur.cnt = cur.cnt - 4'h1;
                next_cur.st = (cur.cnt == 4'h0) ? FPLC_CMD : FPLC_DATA;
            end
            default: begin
                next_cur.st = FPLC_IDLE;
            end
        endcase

        // R23 end of range
        if (!prog_busy && cur.st != FPLC_LOAD && cur.st != FPLC_IDLE && cur.idx == cur.last) begin
            next_cur.st = FPLC_IDLE;
        end

        // R13 first or every entry
        // Requests set after the clear so a rise in the taking cycle is kept
        if (stream_rise && cur.autoload[`FPLC_BIT_AL_STREAM]
            && (cur.autoload[`FPLC_BIT_AL_EVERY] || !cur.first_done)) begin
            next_cur.stream_pend = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cur <= '0;
            cur.st <= FPLC_IDLE;
            cur.mode <= `FPLC_RST_MODE;
            cur.autoload <= `FPLC_RST_AUTOLOAD;
            cur.start_addr <= `FPLC_RST_ADDR;
            cur.end_addr <= `FPLC_RST_ADDR;
            cur.hdr_addr <= `FPLC_RST_ADDR;
            cur.boot_pend <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata_o = cur.rdata;
    assign fuse_cmd_o = cur.fuse;
    assign dev_wr_o = cur.dev;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    logic idle_prog_trig;
    logic idle_load_trig;
    assign idle_prog_trig = reg_req_i.wr && reg_req_i.addr == `FPLC_OFF_PROG
                            && reg_req_i.wdata[`FPLC_BIT_TRIG] && cur.st == FPLC_IDLE;
    assign idle_load_trig = reg_req_i.wr && reg_req_i.addr == `FPLC_OFF_LOAD
                            && reg_req_i.wdata[`FPLC_BIT_TRIG] && cur.st == FPLC_IDLE && !idle_prog_trig;

    prog_start_busy_a: assert property (idle_prog_trig |=> cur.st == FPLC_PROG ##1 // R03
        fuse_cmd_o.req && fuse_cmd_o.we) else $error("program trigger did not start a burn");
    prog_busy_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `FPLC_OFF_PROG // R04
        |=> reg_rdata_o[`FPLC_BIT_BUSY] == $past(cur.st == FPLC_PROG)) else $error("program busy bit wrong");
    load_start_busy_a: assert property (idle_load_trig |=> cur.st == FPLC_LOAD ##1 // R08
        fuse_cmd_o.req && !fuse_cmd_o.we) else $error("load trigger did not start a load");
    busy_trig_ignored_a: assert property (cur.st == FPLC_PROG && reg_req_i.wr // R24
        && reg_req_i.addr == `FPLC_OFF_LOAD |=> cur.st != FPLC_LOAD) else $error("trigger taken while busy");
    fuse_in_range_a: assert property (fuse_cmd_o.req |-> (cur.mode[`FPLC_BIT_PARTIAL] // R01
        || cur.last == `FPLC_IDX_LAST)) else $error("all-byte range not full");
    buf_map_a: assert property (cur.st == FPLC_LOAD && fuse_done |-> buf_we // R21
        && buf_wi == fuse_cmd_o.addr && buf_wd == fuse_rdata_i) else $error("fuse byte mapped wrong");
    boot_load_a: assert property ($fell(reset_i) |-> ##[0:2] cur.st == FPLC_LOAD) // R12
        else $error("no start-up load");
    parse_enter_a: assert property (cur.st == FPLC_LOAD && fuse_done && cur.idx == cur.last // R11
        && !cur.auto_run && cur.autoload[`FPLC_BIT_AL_MANUAL] |=> cur.st == FPLC_CMD)
        else $error("parse stage not entered");
    bad_cmd_stop_a: assert property (cur.st == FPLC_CMD && buf_b[7:4] != `FPLC_CMD_ABSOLUTE // R23
        && buf_b[7:4] != `FPLC_CMD_FOLLOWING |=> cur.st == FPLC_IDLE) else $error("parser ran past bad code");
    dev_incr_a: assert property (dev_wr_o.we ##1 dev_wr_o.we |-> // R17
        dev_wr_o.addr == $past(dev_wr_o.addr) + 16'h0001) else $error("register address not consecutive");

    // Fuse port and load sequencing
    fuse_req_hold_a: assert property (fuse_cmd_o.req && !fuse_ack_i // R03
        |=> fuse_cmd_o.req && $stable(fuse_cmd_o))
        else $error("fuse request changed before ack");
    fuse_req_drop_a: assert property (fuse_done // R07
        |=> !fuse_cmd_o.req)
        else $error("fuse request held after ack");
    load_idx_step_a: assert property (cur.st == FPLC_LOAD && fuse_done && cur.idx != cur.last // R07
        |=> cur.idx == $past(cur.idx) + 10'h001)
        else $error("load index did not step");
    load_busy_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `FPLC_OFF_LOAD // R08
        |=> reg_rdata_o == {$past(load_busy), 7'h00})
        else $error("load busy bit wrong");
    partial_bounds_a: assert property (idle_load_trig && cur.mode[`FPLC_BIT_PARTIAL] // R02
        |=> cur.idx == $past(cur.start_addr[9:0]) && cur.last == $past(cur.end_addr[9:0]))
        else $error("partial range not taken");

    // Record parser
    abs_addr_hi_a: assert property (cur.st == FPLC_ADRH // R15
        |=> cur.dev_addr[15:8] == $past(buf_b))
        else $error("record address high byte lost");
    rec_len_end_a: assert property (cur.st == FPLC_DATA && cur.cnt == 4'h0 && cur.idx != cur.last // R15
        |=> cur.st == FPLC_CMD)
        else $error("record length not kept");
    follow_addr_a: assert property (cur.st == FPLC_CMD && buf_b[7:4] == `FPLC_CMD_FOLLOWING // R16
        && cur.idx != cur.last |=> cur.st == FPLC_DATA && $stable(cur.dev_addr))
        else $error("following record lost its address");
    auto_no_parse_a: assert property (cur.st == FPLC_LOAD && fuse_done && cur.idx == cur.last // R14
        && cur.auto_run && !cur.autoload[`FPLC_BIT_AL_AUTO] |=> cur.st == FPLC_IDLE)
        else $error("parse ran without enable");

    // Streaming reloads
    every_reload_a: assert property (stream_rise && cur.autoload[`FPLC_BIT_AL_STREAM] // R13
        && cur.autoload[`FPLC_BIT_AL_EVERY] |=> cur.stream_pend)
        else $error("streaming reload not requested");
    no_reload_a: assert property (stream_rise && !cur.autoload[`FPLC_BIT_AL_STREAM] && !cur.stream_pend // R12
        |=> !cur.stream_pend)
        else $error("reload requested with streaming reload off");

    prog_done_c: cover property (cur.st == FPLC_PROG ##1 cur.st == FPLC_IDLE);
    abs_record_c: cover property (cur.st == FPLC_ADRL ##2 dev_wr_o.we [*2]);
    follow_record_c: cover property (cur.st == FPLC_CMD && buf_b[7:4] == `FPLC_CMD_FOLLOWING);
    stream_reload_c: cover property (cur.stream_pend && cur.st == FPLC_IDLE);
endmodule // fplc_ctrl

// ==== core/fplc_defs.svh ====
// Register offsets, field positions, reset values and codes of the fuse controller
`ifndef FPLC_DEFS_SVH
`define FPLC_DEFS_SVH
`define FPLC_OFF_PROG 16'h3D80
`define FPLC_OFF_LOAD 16'h3D81
`define FPLC_OFF_MODE 16'h3D84
`define FPLC_OFF_AUTOLOAD 16'h3D85
`define FPLC_OFF_START_HI 16'h3D88
`define FPLC_OFF_START_LO 16'h3D89
`define FPLC_OFF_END_HI 16'h3D8A
`define FPLC_OFF_END_LO 16'h3D8B
`define FPLC_OFF_HDR_HI 16'h3D8C
`define FPLC_OFF_HDR_LO 16'h3D8D
`define FPLC_BUF_FIRST 16'h7000
`define FPLC_BUF_LAST 16'h73FF
`define FPLC_IDX_FIRST 10'h000
`define FPLC_IDX_LAST 10'h3FF
`define FPLC_BIT_TRIG 0
`define FPLC_BIT_BUSY 7
`define FPLC_BIT_PARTIAL 6
`define FPLC_BIT_AL_MANUAL 0
`define FPLC_BIT_AL_AUTO 1
`define FPLC_BIT_AL_STREAM 2
`define FPLC_BIT_AL_EVERY 3
`define FPLC_RST_MODE 8'h00
`define FPLC_RST_AUTOLOAD 8'h00
`define FPLC_RST_ADDR 16'h0000
`define FPLC_RST_BYTE 8'h00
`define FPLC_CMD_ABSOLUTE 4'hA
`define FPLC_CMD_FOLLOWING 4'h5
`endif

// ==== core/fplc_pkg.sv ====
// Types shared by the fuse program and load controller
package fplc_pkg;
    typedef enum logic [6:0] {
        FPLC_IDLE = 7'b0000001,
        FPLC_PROG = 7'b0000010,
        FPLC_LOAD = 7'b0000100,
        FPLC_CMD = 7'b0001000,
        FPLC_ADRH = 7'b0010000,
        FPLC_ADRL = 7'b0100000,
        FPLC_DATA = 7'b1000000
    } fplc_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fplc_reg_req_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [9:0] addr;
        logic [7:0] wdata;
    } fplc_fuse_cmd_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } fplc_dev_wr_s;

    typedef struct packed {
        fplc_state_e st;
        logic [7:0] mode;
        logic [7:0] autoload;
        logic [15:0] start_addr;
        logic [15:0] end_addr;
        logic [15:0] hdr_addr;
        logic [9:0] idx;
        logic [9:0] last;
        logic auto_run;
        logic boot_pend;
        logic stream_pend;
        logic first_done;
        logic stream_q;
        logic [3:0] cnt;
        logic [15:0] dev_addr;
        logic [7:0] rdata;
        fplc_fuse_cmd_s fuse;
        fplc_dev_wr_s dev;
    } fplc_ctrl_s;

    typedef struct packed {
        logic [1023:0][7:0] mem;
    } fplc_buf_s;
endpackage : fplc_pkg

// ==== core/fplc_stage_buf.sv ====
// Staging buffer of 1024 bytes between the register port and the fuse array
module fplc_stage_buf
    import fplc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Write port
    input wire logic wr_i,
    input wire logic [9:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    // Read port for the host, registered in the controller
    input wire logic [9:0] rd_a_idx_i,
    output logic [7:0] rd_a_data_o,
    // Direct read port for the sequencer
    input wire logic [9:0] rd_b_idx_i,
    output logic [7:0] rd_b_data_o
);
    fplc_buf_s cur;
    fplc_buf_s next_cur;

    always_comb begin
        next_cur = cur;
        if (wr_i) begin
            next_cur.mem[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Unregistered here so the controller's read register sees the address of the taking cycle
    assign rd_a_data_o = cur.mem[rd_a_idx_i];
    assign rd_b_data_o = cur.mem[rd_b_idx_i];
endmodule // fplc_stage_buf

// ==== sim/fplc_ctrl_bench.sv ====
// Self-checking bench for the fuse program and load controller
`include "fplc_defs.svh"

module fplc_ctrl_bench
    import fplc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, reset_i, stream_on, fuse_ack, slow;
    logic [7:0] reg_rdata, fuse_rdata;
    fplc_reg_req_s req;
    fplc_fuse_cmd_s fuse_cmd;
    fplc_dev_wr_s dev_wr;
    int bad_count, check_count;
    logic [7:0] fz [1024];
    logic [7:0] rec [8];
    logic [23:0] devq [$];

    fplc_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(reg_rdata),
        .stream_on_i(stream_on), .fuse_cmd_o(fuse_cmd), .fuse_ack_i(fuse_ack),
        .fuse_rdata_i(fuse_rdata), .dev_wr_o(dev_wr));
    fplc_fuse_model fuse (.clk_i(clk_i), .fuse_cmd_i(fuse_cmd), .slow_i(slow),
        .fuse_ack_o(fuse_ack), .fuse_rdata_o(fuse_rdata));

    always #50 clk_i = ~clk_i;

    always @(negedge clk_i) begin
        if (dev_wr.we === 1'b1) begin
            devq.push_back({dev_wr.addr, dev_wr.data});
        end
    end

    function automatic logic [7:0] fuse_init(input int k);
        return k[9] ? 8'h00 : (k[7:0] ^ 8'hA5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_i);
        req.wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_i);
        req.rd = 1'b0;
        @(negedge clk_i);
        d = reg_rdata;
    endtask

    task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check(d, exp);
    endtask

    // Busy polled until clear, bounded at 4000 reads so a stuck bit ends the wait with a failed check
    task automatic wait_idle(input logic [15:0] a);
        logic [7:0] d;
        int n;
        n = 0;
        do begin
            reg_rd(a, d);
            n++;
        end while (d[7] !== 1'b0 && n < 4000);
        check(d[7], 1'b0);
    endtask

    task automatic trig(input logic [15:0] a);
        slow = 1'($urandom % 2);
        reg_wr(a, 8'h01);
        repeat (2) @(negedge clk_i);
    endtask

    task automatic set_range(input logic [15:0] s, input logic [15:0] e);
        reg_wr(`FPLC_OFF_START_HI, s[15:8]);
        reg_wr(`FPLC_OFF_START_LO, s[7:0]);
        reg_wr(`FPLC_OFF_END_HI, e[15:8]);
        reg_wr(`FPLC_OFF_END_LO, e[7:0]);
    endtask

    task automatic stream_cycle();
        @(negedge clk_i);
        stream_on = 1'b0;
        repeat (3) @(negedge clk_i);
        stream_on = 1'b1;
        repeat (3) @(negedge clk_i);
        wait_idle(`FPLC_OFF_LOAD);
    endtask

    // Probe byte is spoiled, then restored only if a reload ran
    task automatic auto_case(input logic [7:0] al, input logic reload);
        reg_wr(`FPLC_OFF_AUTOLOAD, al);
        reg_wr(16'h7005, ~fz[5]);
        stream_cycle();
        rd_check(16'h7005, reload ? fz[5] : ~fz[5]);
    endtask

    task automatic expect_parse(input int reps);
        check(devq.size(), 4 * reps);
        for (int i = 0; i < devq.size(); i++) begin
            check(devq[i], {16'h1234 + 16'(i % 4), rec[(i % 4 < 2) ? 3 + i % 4 : 4 + i % 4]});
        end
        devq.delete();
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [15:0] offs [11];
        logic [9:0] k0;
        logic [7:0] v;
        clk_i = 1'b0;
        reset_i = 1'b1;
        stream_on = 1'b0;
        slow = 1'b0;
        req = '0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(80764));
        for (int k = 0; k < 1024; k++) begin
            fz[k] = fuse_init(k);
        end
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_i);
        wait_idle(`FPLC_OFF_LOAD);
        offs = '{`FPLC_OFF_PROG, `FPLC_OFF_LOAD, `FPLC_OFF_MODE, `FPLC_OFF_AUTOLOAD, `FPLC_OFF_START_HI,
            `FPLC_OFF_START_LO, `FPLC_OFF_END_HI, `FPLC_OFF_END_LO, `FPLC_OFF_HDR_HI, `FPLC_OFF_HDR_LO, 16'h3D90};
        foreach (offs[i]) begin
            rd_check(offs[i], 8'h00);
        end
        rd_check(`FPLC_BUF_FIRST, fz[0]);
        rd_check(`FPLC_BUF_LAST, fz[1023]);
        repeat (6) begin
            k0 = 10'($urandom);
            rd_check(16'h7000 + 16'(k0), fz[k0]);
        end
        for (int i = 4; i < 10; i++) begin
            v = 8'($urandom);
            reg_wr(offs[i], v);
            rd_check(offs[i], v);
        end
        // busy and spare bits hold nothing
        reg_wr(`FPLC_OFF_PROG, 8'hFE);
        rd_check(`FPLC_OFF_PROG, 8'h00);
        reg_wr(`FPLC_OFF_MODE, 8'h40);
        set_range(16'h7000, 16'h700F);
        auto_case(8'h04, 1'b1);
        auto_case(8'h04, 1'b0);
        auto_case(8'h0C, 1'b1);
        auto_case(8'h00, 1'b0);
        // streaming stays on; buffer filled before burning
        k0 = 10'h020 + 10'($urandom % 400);
        set_range(16'h7000 + 16'(k0), 16'h7003 + 16'(k0));
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            fz[k0 + 10'(i)] = fz[k0 + 10'(i)] | v;
            reg_wr(16'h7000 + 16'(k0 + 10'(i)), v);
        end
        trig(`FPLC_OFF_PROG);
        rd_check(`FPLC_OFF_PROG, 8'h80);
        reg_wr(`FPLC_OFF_LOAD, 8'h01);
        rd_check(`FPLC_OFF_LOAD, 8'h00);
        wait_idle(`FPLC_OFF_PROG);
        for (int i = -1; i < 5; i++) begin
            reg_wr(16'h7000 + 16'(k0) + 16'(i), ~fz[k0 + 10'(i)]);
        end
        // load only once programming is done
        trig(`FPLC_OFF_LOAD);
        wait_idle(`FPLC_OFF_LOAD);
        for (int i = -1; i < 5; i++) begin
            rd_check(16'h7000 + 16'(k0) + 16'(i), (i < 0 || i > 3) ? ~fz[k0 + 10'(i)] : fz[k0 + 10'(i)]);
        end
        rec = '{8'hA1, 8'h12, 8'h34, 8'($urandom), 8'($urandom), 8'h51, 8'($urandom), 8'($urandom)};
        set_range(16'h7380, 16'h7387);
        for (int i = 0; i < 8; i++) begin
            reg_wr(16'h7380 + 16'(i), rec[i]);
        end
        trig(`FPLC_OFF_PROG);
        wait_idle(`FPLC_OFF_PROG);
        // spare blank bytes follow the records
        set_range(16'h7380, 16'h738F);
        reg_wr(`FPLC_OFF_HDR_HI, 8'h73);
        reg_wr(`FPLC_OFF_HDR_LO, 8'h80);
        devq.delete();
        reg_wr(`FPLC_OFF_AUTOLOAD, 8'h01);
        trig(`FPLC_OFF_LOAD);
        wait_idle(`FPLC_OFF_LOAD);
        expect_parse(1);
        reg_wr(`FPLC_OFF_AUTOLOAD, 8'h02);
        trig(`FPLC_OFF_LOAD);
        wait_idle(`FPLC_OFF_LOAD);
        expect_parse(0);
        reg_wr(`FPLC_OFF_AUTOLOAD, 8'h0E);
        stream_cycle();
        expect_parse(1);
        wrap_up();
    end
endmodule // fplc_ctrl_bench

// ==== sim/fplc_fuse_model.sv ====
// Behavioural fuse array that answers the controller's fuse port
module fplc_fuse_model
    import fplc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Fuse port
    input wire fplc_fuse_cmd_s fuse_cmd_i,
    input wire logic slow_i,
    output logic fuse_ack_o,
    output logic [7:0] fuse_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem [1024];
    logic [1:0] wait_q;

    // Upper half starts blank so burned records read back exactly
    initial begin
        for (int k = 0; k < 1024; k++) begin
            mem[k] = k[9] ? 8'h00 : (k[7:0] ^ 8'hA5);
        end
        wait_q = 2'h0;
        fuse_ack_o = 1'b0;
        fuse_rdata_o = 8'h00;
    end

    // One ack per request, three extra cycles when slow
    always @(posedge clk_i) begin
        fuse_ack_o <= 1'b0;
        // Stale data flips so a late sample never matches by luck
        fuse_rdata_o <= ~fuse_rdata_o;
        if (fuse_cmd_i.req === 1'b1 && !fuse_ack_o) begin
            if (slow_i && wait_q != 2'h3) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                wait_q <= 2'h0;
                fuse_ack_o <= 1'b1;
                if (fuse_cmd_i.we) begin
                    // Burning can only set bits
                    mem[fuse_cmd_i.addr] <= mem[fuse_cmd_i.addr] | fuse_cmd_i.wdata;
                end else begin
                    fuse_rdata_o <= mem[fuse_cmd_i.addr];
                end
            end
        end
    end
endmodule // fplc_fuse_model
